/* design/dsadc_controller.sv */
// Controller end: makes trigger and conversion clock, shifts in data
// Assumes the converter shares mclk_in; data pins pass synchronisers
`timescale 1ns/100ps
module dsadc_controller #(
	parameter int unsigned DATA_W = 18
) (
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// Link
	dsadc_if.controller            link,
	// User side
	input  wire logic              start_in,
	output logic                   busy_out,
	output logic                   done_out,
	output logic [DATA_W-1:0]      word_a_out,
	output logic [DATA_W-1:0]      word_b_out
);
	// =========================================================
	// Sequencer
	dsadc_pkg::dsadc_ctl_e st_q;
	logic [7:0]            tmr_q;
	logic [4:0]            edges_q;
	logic                  trig_q;
	logic                  cclk_q;
	logic [1:0]            sa_q;
	logic [1:0]            sb_q;
	logic [DATA_W-1:0]     sh_a_q;
	logic [DATA_W-1:0]     sh_b_q;
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			sa_q <= 2'h0;
			sb_q <= 2'h0;
		end
		else
		begin
			sa_q <= {sa_q[0], link.serial_data_a};
			sb_q <= {sb_q[0], link.serial_data_b};
		end
	end
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			st_q    <= dsadc_pkg::DSADC_IDLE;
			tmr_q   <= 8'h00;
			edges_q <= 5'h00;
			trig_q  <= 1'b0;
			cclk_q  <= 1'b0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			case (st_q)
				dsadc_pkg::DSADC_IDLE:
					if (start_in)
					begin
						trig_q <= 1'b1;
						tmr_q  <= 8'(dsadc_pkg::TRIG_HIGH_CYC);
						edges_q <= 5'h00;
						st_q   <= dsadc_pkg::DSADC_TRIG;
					end
				dsadc_pkg::DSADC_TRIG:
					if (tmr_q <= 8'h01)
					begin
						trig_q <= 1'b0;
						tmr_q  <= 8'(dsadc_pkg::MSB_SETTLE_CYC);
						st_q   <= dsadc_pkg::DSADC_SETTLE;
					end
					else
						tmr_q <= tmr_q - 8'h01;
				dsadc_pkg::DSADC_SETTLE:
					if (tmr_q <= 8'h01)
					begin
						tmr_q <= 8'(dsadc_pkg::HALF_PERIOD_CYC);
						st_q  <= dsadc_pkg::DSADC_CLK_LO;
					end
					else
						tmr_q <= tmr_q - 8'h01;
				dsadc_pkg::DSADC_CLK_LO:
					if (tmr_q <= 8'h01)
					begin
						cclk_q  <= 1'b1;
						edges_q <= edges_q + 5'h01;
						tmr_q   <= 8'(dsadc_pkg::HALF_PERIOD_CYC);
						st_q    <= dsadc_pkg::DSADC_CLK_HI;
					end
					else
						tmr_q <= tmr_q - 8'h01;
				dsadc_pkg::DSADC_CLK_HI:
					if (tmr_q <= 8'h01)
					begin
						cclk_q <= 1'b0;
						tmr_q  <= 8'(dsadc_pkg::HALF_PERIOD_CYC);
						if (edges_q == 5'(dsadc_pkg::LAST_EDGE))
							st_q <= dsadc_pkg::DSADC_DONE;
						else
							st_q <= dsadc_pkg::DSADC_CLK_LO;
					end
					else
						tmr_q <= tmr_q - 8'h01;
				dsadc_pkg::DSADC_DONE:
					if (tmr_q <= 8'h01)
					begin
						done_out <= 1'b1;
						st_q     <= dsadc_pkg::DSADC_IDLE;
					end
					else
						tmr_q <= tmr_q - 8'h01;
				default:
					st_q <= dsadc_pkg::DSADC_IDLE;
			endcase
		end
	end
	// =========================================================
	// Bit capture one clock period after each output edge
	logic cap;
	logic cap_last;
	assign cap_last = (st_q == dsadc_pkg::DSADC_DONE) && (tmr_q <= 8'h01);
	assign cap = ((st_q == dsadc_pkg::DSADC_CLK_LO) && (tmr_q <= 8'h01)
		&& (edges_q >= 5'h02)) || cap_last;
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			sh_a_q <= '0;
			sh_b_q <= '0;
		end
		else if (cap)
		begin
			sh_a_q <= {sh_a_q[DATA_W-2:0], sa_q[1]};
			sh_b_q <= {sh_b_q[DATA_W-2:0], sb_q[1]};
		end
	end
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			word_a_out <= '0;
			word_b_out <= '0;
		end
		else if (cap_last)
		begin
			word_a_out <= {sh_a_q[DATA_W-2:0], sa_q[1]};
			word_b_out <= {sh_b_q[DATA_W-2:0], sb_q[1]};
		end
	end
	assign busy_out = (st_q != dsadc_pkg::DSADC_IDLE);
	assign link.convert_trigger     = trig_q;
	assign link.conversion_clock_in = cclk_q;
endmodule // dsadc_controller

/* design/dsadc_pkg.sv */
// Shared constants for the dual SAR converter sequencer and its controller
// Assumes both ends run on mclk_in at 125 MHz
package dsadc_pkg;
	// =========================================================
	// Word format
	localparam int unsigned DATA_BITS   = 18;
	localparam int unsigned LAST_EDGE   = 19;
	localparam int unsigned CNT_W       = 5;
	localparam logic [17:0] CODE_POS_FS = 18'h1ffff;
	localparam logic [17:0] CODE_ZERO   = 18'h00000;
	localparam logic [17:0] CODE_NEG_1  = 18'h3ffff;
	localparam logic [17:0] CODE_NEG_FS = 18'h20000;
	// =========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_PS     = 8000;
	localparam int unsigned TRIG_HIGH_NS      = 81;
	localparam int unsigned TRIG_LOW_SETUP_NS = 50;
	localparam int unsigned MSB_SETTLE_NS     = 200;
	localparam int unsigned TRIG_HIGH_CYC =
		(TRIG_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SETUP_CYC =
		(TRIG_LOW_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned MSB_SETTLE_CYC =
		(MSB_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned HALF_PERIOD_CYC = 4;
	localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
	// =========================================================
	// Controller states
	typedef enum logic [2:0] {
		DSADC_IDLE,
		DSADC_TRIG,
		DSADC_SETTLE,
		DSADC_CLK_LO,
		DSADC_CLK_HI,
		DSADC_DONE
	} dsadc_ctl_e;
endpackage

/* design/dsadc_if.sv */
// Link between converter sequencer and its controller
// Assumes the testbench provides the common clock
`timescale 1ns/100ps
interface dsadc_if;
	logic        convert_trigger;
	logic        conversion_clock_in;
	logic        serial_data_a;
	logic        serial_data_b;
	modport converter (
		input  convert_trigger,
		input  conversion_clock_in,
		output serial_data_a,
		output serial_data_b
	);
	modport controller (
		output convert_trigger,
		output conversion_clock_in,
		input  serial_data_a,
		input  serial_data_b
	);
endinterface

/* design/dsadc_converter.sv */
// Converter end: conversion sequencer with serial result outputs
// Assumes trigger and clock arrive from a pin; comparator as inputs
//
// Behaviour
// - Conversion starts on trigger rising edge only
// - Controller drops trigger before edge 19
// - Controller trigger pulse 11 clocks, at least 81ns wide
// - Act only on rising clock edges
// - Controller captures data on rising edge; the LSB is taken at the end of DONE, with the clock halted and no edge
// - Block clock edges after the 19th
// - Return to tracking at edge 19
// - No clock edge in settle window
// - Controller halts clock after 19th edge
// - Results are 18-bit two's complement words
// - Resolve 18 bits per channel
// - Trigger spacing has no upper limit
// - Both channels enter hold together
// - MSB first, one bit per edge, shared
// - Each bit output one edge after decision
`timescale 1ns/100ps
module dsadc_converter #(
	parameter int unsigned DATA_W = 18
) (
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// Link
	dsadc_if.converter             link,
	// Comparator decisions per channel
	input  wire logic              cmp_a_in,
	input  wire logic              cmp_b_in,
	// Status
	output logic                   hold_out,
	output logic                   bit_strobe_out,
	output logic [DATA_W-1:0]      result_a_out,
	output logic [DATA_W-1:0]      result_b_out
);
	// =========================================================
	// Pin synchronisers
	logic [1:0] trig_sync_q;
	logic [1:0] clk_sync_q;
	logic       trig_prev_q;
	logic       clk_prev_q;
	logic       trig_rise;
	logic       clk_rise;
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			trig_sync_q <= 2'h0;
			clk_sync_q  <= 2'h0;
			trig_prev_q <= 1'b0;
			clk_prev_q  <= 1'b0;
		end
		else
		begin
			trig_sync_q <= {trig_sync_q[0], link.convert_trigger};
			clk_sync_q  <= {clk_sync_q[0], link.conversion_clock_in};
			trig_prev_q <= trig_sync_q[1];
			clk_prev_q  <= clk_sync_q[1];
		end
	end
	assign trig_rise = trig_sync_q[1] & ~trig_prev_q;
	assign clk_rise  = clk_sync_q[1] & ~clk_prev_q;
	// =========================================================
	// Edge counter and lockout
	logic [dsadc_pkg::CNT_W-1:0] edge_cnt_q;
	logic                        below_last;
	logic                        at_last;
	logic                        accept;
	assign below_last = edge_cnt_q < 5'(dsadc_pkg::LAST_EDGE);
	assign at_last    = edge_cnt_q == 5'(dsadc_pkg::LAST_EDGE - 1);
	assign accept     = clk_rise & hold_out & ~trig_rise
		& below_last;
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			edge_cnt_q <= dsadc_pkg::CNT_RESET;
		else if (trig_rise)
			edge_cnt_q <= dsadc_pkg::CNT_RESET;
		else if (accept)
			edge_cnt_q <= edge_cnt_q + 5'h01;
	end
	// =========================================================
	// Track and hold
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			hold_out <= 1'b0;
		else if (trig_rise)
			hold_out <= 1'b1;
		else if (accept && at_last)
			hold_out <= 1'b0;
	end
	assign bit_strobe_out = accept;

	// =========================================================
	// Shared one-hot bit sequence, both channels in step
	logic [dsadc_pkg::LAST_EDGE-1:0] seq_q;
	logic [dsadc_pkg::LAST_EDGE-1:0] seq_first;
	assign seq_first = {1'b1, {(dsadc_pkg::LAST_EDGE - 1){1'b0}}};
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			seq_q <= '0;
		else if (trig_rise)
			seq_q <= seq_first;
		else if (accept)
			seq_q <= seq_q >> 1;
	end

	// =========================================================
	// Decision latches, one per bit and channel
	logic [DATA_W-1:0] sar_a;
	logic [DATA_W-1:0] sar_b;
	for (genvar i = 0; i < DATA_W; i++)
	begin : g_bit
		logic dec_a_q;
		logic dec_b_q;
		always_ff @(posedge mclk_in)
		begin
			if (!rst_n_in || trig_rise)
			begin
				dec_a_q <= 1'b0;
				dec_b_q <= 1'b0;
			end
			else if (accept && seq_q[i+1])
			begin
				dec_a_q <= cmp_a_in;
				dec_b_q <= cmp_b_in;
			end
		end
		assign sar_a[i] = dec_a_q;
		assign sar_b[i] = dec_b_q;
	end

	// =========================================================
	// Serial outputs, one accepted edge behind each decision
	logic dout_a_q;
	logic dout_b_q;
	logic next_a;
	logic next_b;
	assign next_a = |(seq_q[DATA_W-1:0] & sar_a);
	assign next_b = |(seq_q[DATA_W-1:0] & sar_b);
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			dout_a_q <= 1'b0;
			dout_b_q <= 1'b0;
		end
		else if (accept && !seq_q[dsadc_pkg::LAST_EDGE-1])
		begin
			dout_a_q <= next_a;
			dout_b_q <= next_b;
		end
	end
	assign link.serial_data_a = dout_a_q;
	assign link.serial_data_b = dout_b_q;

	// =========================================================
	// Result words, two's complement as resolved
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			result_a_out <= '0;
			result_b_out <= '0;
		end
		else if (accept && at_last)
		begin
			result_a_out <= sar_a;
			result_b_out <= sar_b;
		end
	end
endmodule // dsadc_converter

/* test/dsadc_asserts.sv */
// Checker on the link wires between converter and controller
// Assumes it is instantiated beside the dsadc_if in the testbench
`timescale 1ns/100ps
module dsadc_asserts (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// Link wires
	input  wire logic convert_trigger,
	input  wire logic conversion_clock_in,
	input  wire logic serial_data_a,
	input  wire logic serial_data_b
);
	// ==========================================================
	// Edge and cycle counters
	logic [4:0] edges_q;
	logic [5:0] since_trig_q;
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || $rose(convert_trigger))
			edges_q <= 5'h00;
		else if ($rose(conversion_clock_in) && edges_q != 5'h13)
			edges_q <= edges_q + 5'h01;
	end
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in || $rose(convert_trigger))
			since_trig_q <= 6'h00;
		else if (since_trig_q != 6'h3f)
			since_trig_q <= since_trig_q + 6'h01;
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	property p_trig_width;
		$rose(convert_trigger) |-> convert_trigger [*8] ##1
			convert_trigger [*3] ##1 !convert_trigger;
	endproperty
	a_trig_width: assert property (p_trig_width)
		else $error("trigger pulse width wrong");
	property p_settle;
		$rose(conversion_clock_in) && edges_q == 5'h00 |->
			since_trig_q >= 6'h19;
	endproperty
	a_settle: assert property (p_settle)
		else $error("clock rise inside settle window");
	property p_trig_setup;
		$rose(conversion_clock_in) && edges_q == 5'h12 |->
			!convert_trigger && !$past(convert_trigger, 7);
	endproperty
	a_trig_setup: assert property (p_trig_setup)
		else $error("trigger not low before last clock");
	property p_clk_high;
		$rose(conversion_clock_in) |-> conversion_clock_in [*4] ##1
			!conversion_clock_in;
	endproperty
	a_clk_high: assert property (p_clk_high)
		else $error("clock high time wrong");
	property p_clk_low;
		$fell(conversion_clock_in) && edges_q != 5'h13 |->
			!conversion_clock_in [*4] ##1 conversion_clock_in;
	endproperty
	a_clk_low: assert property (p_clk_low)
		else $error("clock low time wrong");
	property p_clk_halt;
		$rose(conversion_clock_in) |-> edges_q != 5'h13;
	endproperty
	a_clk_halt: assert property (p_clk_halt)
		else $error("clock edge after the last one");
	property p_data_order;
		$changed(serial_data_a) || $changed(serial_data_b) |->
			edges_q >= 5'h02;
	endproperty
	a_data_order: assert property (p_data_order)
		else $error("serial data moved before second edge");
	property p_data_at_rise;
		$rose(conversion_clock_in) |->
			$stable(serial_data_a) && $stable(serial_data_b);
	endproperty
	a_data_at_rise: assert property (p_data_at_rise)
		else $error("serial data moved at clock rise");
	property p_trig_order;
		$rose(convert_trigger) |-> edges_q == 5'h00 || edges_q == 5'h13;
	endproperty
	a_trig_order: assert property (p_trig_order)
		else $error("trigger inside a conversion");
endmodule // dsadc_asserts

/* test/dsadc_tb.sv */
// Bench joining converter and controller over the link
// Assumes package and link interface are compiled first
`timescale 1ns/100ps
module dsadc_tb;
	// ==========================================================
	// Signals
	logic        mclk_in  = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        start_in = 1'b0;
	logic        cmp_a    = 1'b0;
	logic        cmp_b    = 1'b0;
	logic        hold, strobe, busy, done;
	logic [17:0] res_a, res_b, word_a, word_b, drv_a, drv_b;
	int          failures = 0;
	int          checks   = 0;
	int          nstrb    = 0;
	int          strobes  = 0;
	logic [17:0] rows [5][4] = '{
		'{dsadc_pkg::CODE_POS_FS, dsadc_pkg::CODE_NEG_FS,
			dsadc_pkg::CODE_POS_FS, dsadc_pkg::CODE_NEG_FS},
		'{dsadc_pkg::CODE_ZERO, dsadc_pkg::CODE_NEG_1,
			dsadc_pkg::CODE_ZERO, dsadc_pkg::CODE_NEG_1},
		'{dsadc_pkg::CODE_NEG_1, dsadc_pkg::CODE_ZERO,
			dsadc_pkg::CODE_NEG_1, dsadc_pkg::CODE_ZERO},
		'{dsadc_pkg::CODE_NEG_FS, dsadc_pkg::CODE_POS_FS,
			dsadc_pkg::CODE_NEG_FS, dsadc_pkg::CODE_POS_FS},
		'{18'h2aaaa, 18'h15555, 18'h2aaaa, 18'h15555}};
	always #4 mclk_in = ~mclk_in;
	// ==========================================================
	// Design and checker
	dsadc_if dsadc_if_i ();
	dsadc_converter dsadc_converter_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .link(dsadc_if_i.converter),
		.cmp_a_in(cmp_a), .cmp_b_in(cmp_b), .hold_out(hold),
		.bit_strobe_out(strobe), .result_a_out(res_a),
		.result_b_out(res_b));
	dsadc_controller dsadc_controller_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .link(dsadc_if_i.controller),
		.start_in(start_in), .busy_out(busy), .done_out(done),
		.word_a_out(word_a), .word_b_out(word_b));
	dsadc_asserts dsadc_asserts_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.convert_trigger(dsadc_if_i.convert_trigger),
		.conversion_clock_in(dsadc_if_i.conversion_clock_in),
		.serial_data_a(dsadc_if_i.serial_data_a),
		.serial_data_b(dsadc_if_i.serial_data_b));
	// ==========================================================
	// Comparator decisions, MSB first
	always @(negedge mclk_in)
	begin
		if (hold !== 1'b1)
			nstrb = 0;
		else if (strobe === 1'b1)
		begin
			if (nstrb < 18)
			begin
				cmp_a = drv_a[17 - nstrb];
				cmp_b = drv_b[17 - nstrb];
			end
			nstrb++;
		end
		if (strobe === 1'b1)
			strobes++;
	end
	// ==========================================================
	// Tasks
	task automatic chk_word(input string nm, input logic [17:0] e,
		input logic [17:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {17'h00000, e}, {17'h00000, g});
	endtask
	task automatic conv(input logic [17:0] a, input logic [17:0] b,
		input logic [17:0] ea, input logic [17:0] eb);
		int n;
		int s0;
		@(negedge mclk_in);
		drv_a = a;
		drv_b = b;
		s0 = strobes;
		start_in = 1'b1;
		@(negedge mclk_in);
		start_in = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(negedge mclk_in);
			n++;
			start_in = (n == 60);
			if (n == 60)
			begin
				chk_bit("hold", 1'b1, hold);
				chk_bit("busy", 1'b1, busy);
			end
		end
		chk_bit("done", 1'b1, done);
		chk_word("strobes", 18'h00013, 18'(strobes - s0));
		chk_word("word_a", ea, word_a);
		chk_word("word_b", eb, word_b);
		chk_word("result_a", ea, res_a);
		chk_word("result_b", eb, res_b);
		chk_bit("hold", 1'b0, hold);
		chk_bit("serial_a", ea[0], dsadc_if_i.serial_data_a);
		chk_bit("serial_b", eb[0], dsadc_if_i.serial_data_b);
	endtask
	task automatic wrap_up;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// Sequence
	initial
	begin
		repeat (2) @(negedge mclk_in);
		chk_bit("busy", 1'b0, busy);
		chk_word("word_a", 18'h00000, word_a);
		rst_n_in = 1'b1;
		for (int r = 0; r < 5; r++)
			conv(rows[r][0], rows[r][1], rows[r][2], rows[r][3]);
		@(negedge mclk_in);
		start_in = 1'b1;
		@(negedge mclk_in);
		start_in = 1'b0;
		repeat (80) @(negedge mclk_in);
		rst_n_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		chk_bit("hold", 1'b0, hold);
		chk_bit("busy", 1'b0, busy);
		rst_n_in = 1'b1;
		conv(18'h15555, 18'h2aaaa, 18'h15555, 18'h2aaaa);
		wrap_up;
	end
	initial
	begin
		#40000;
		failures++;
		wrap_up;
	end
endmodule // dsadc_tb
